// ==== shared/fcb_params.svh ====
// Constants for the channel B upper-tap coefficient bank.
// Assumes inclusion by bare name from the package and the core module.
`ifndef FCB_PARAMS_SVH
`define FCB_PARAMS_SVH

// Printed offsets are not all multiples of four: these are indices,
// the byte address is four times the index.
`define FCB_IDX_CENTER      12'h450
`define FCB_IDX_TAP6        12'h453
`define FCB_IDX_TAP7        12'h455
`define FCB_IDX_TAP8        12'h457
`define FCB_IDX_TAP9        12'h459
// Dual-channel mode control register, index of own choosing
`define FCB_IDX_MODE        12'h460
`define FCB_IDX_MSB         13
`define FCB_IDX_LSB         2

`define FCB_CENTER_REG_W    24
`define FCB_CENTER_COEF_W   18
`define FCB_OUTER_REG_W     16
`define FCB_OUTER_COEF_W    12
`define FCB_RESET_VALUE     32'h0000_0000
`define FCB_HTRANS_NONSEQ   2'h2
`define FCB_HTRANS_SEQ      2'h3

`endif

// ==== shared/fcb_pkg.sv ====
// Types for the channel B upper-tap coefficient bank.
// Assumes fcb_params.svh is on the include path.
`include "fcb_params.svh"

package fcb_pkg;

    // Coefficients as applied to the filter datapath
    typedef struct packed {
        logic signed [`FCB_CENTER_COEF_W-1:0] center;
        logic signed [`FCB_OUTER_COEF_W-1:0]  tap6;
        logic signed [`FCB_OUTER_COEF_W-1:0]  tap7;
        logic signed [`FCB_OUTER_COEF_W-1:0]  tap8;
        logic signed [`FCB_OUTER_COEF_W-1:0]  tap9;
    } fcb_coefs_t;

    typedef enum logic [0:0] {
        FCB_IDLE = 1'b0,
        FCB_DATA = 1'b1
    } fcb_phase_t;

    // Whole state of the bank
    typedef struct packed {
        fcb_phase_t                   phase;
        logic                         write;
        logic [`FCB_IDX_MSB:`FCB_IDX_LSB] idx;
        logic [`FCB_CENTER_REG_W-1:0] center;
        logic [`FCB_OUTER_REG_W-1:0]  tap6;
        logic [`FCB_OUTER_REG_W-1:0]  tap7;
        logic [`FCB_OUTER_REG_W-1:0]  tap8;
        logic [`FCB_OUTER_REG_W-1:0]  tap9;
        logic                         dual_mode;
        logic [31:0]                  hrdata;
        fcb_coefs_t                   coefs;
        logic                         coefs_valid;
    } fcb_state_t;

endpackage

// ==== core/fcb_coef_bank.sv ====
// AHB-Lite register bank for channel B upper equalizer_fir taps.
// Assumes one AHB-Lite master, word transfers, clk_i at 125 MHz.
//
// Behaviour
// - Stored taps are presented to the filter as signed two's complement values.
// - Center tap register is 24 bits holding an 18-bit coefficient.
// - Readback forces each coefficient field MSB to zero; stored value kept.
// - Sixth tap is bits 11:0 of 16-bit register; 15:12 reserved read/write.
// - Following registers hold seventh and eighth taps, 12-bit signed.
// - Last register holds ninth tap, 12-bit signed.
// - Registers decoded at indices 0x450, 0x453, 0x455, 0x457, 0x459.
// - All registers, reserved bits included, reset to zero.
// - Coefficients drive coefs_o in every mode; coefs_valid_o is set only in dual-channel mode.
`include "fcb_params.svh"
`timescale 1ns/100ps
`default_nettype none

module fcb_coef_bank (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output fcb_pkg::fcb_coefs_t coefs_o,
    output logic             coefs_valid_o,
    output logic             dual_mode_o
);

    fcb_pkg::fcb_state_t st;
    fcb_pkg::fcb_state_t next_st;
    logic                addr_take;
    logic [31:0]         rd_mux;

    // Address phase accepted; slave is always ready
    assign addr_take = hsel_i && hready_i &&
                       (htrans_i == `FCB_HTRANS_NONSEQ || htrans_i == `FCB_HTRANS_SEQ);

    // Read mux from the live address-phase index, registered so data is ready in the data phase
    always_comb begin
        rd_mux = `FCB_RESET_VALUE;
        case (haddr_i[`FCB_IDX_MSB:`FCB_IDX_LSB])
            `FCB_IDX_CENTER: begin
                rd_mux[`FCB_CENTER_REG_W-1:0] = st.center;
                rd_mux[`FCB_CENTER_COEF_W-1] = 1'b0;
            end
            `FCB_IDX_TAP6: begin
                rd_mux[`FCB_OUTER_REG_W-1:0] = st.tap6;
                rd_mux[`FCB_OUTER_COEF_W-1] = 1'b0;
            end
            `FCB_IDX_TAP7: begin
                rd_mux[`FCB_OUTER_REG_W-1:0] = st.tap7;
                rd_mux[`FCB_OUTER_COEF_W-1] = 1'b0;
            end
            `FCB_IDX_TAP8: begin
                rd_mux[`FCB_OUTER_REG_W-1:0] = st.tap8;
                rd_mux[`FCB_OUTER_COEF_W-1] = 1'b0;
            end
            `FCB_IDX_TAP9: begin
                rd_mux[`FCB_OUTER_REG_W-1:0] = st.tap9;
                rd_mux[`FCB_OUTER_COEF_W-1] = 1'b0;
            end
            `FCB_IDX_MODE: begin
                rd_mux[0] = st.dual_mode;
            end
            default: begin
                rd_mux = `FCB_RESET_VALUE;
            end
        endcase
    end

    // Next-state logic
    always_comb begin
        next_st = st;
        // Data phase write lands with hwdata
        if (st.phase == fcb_pkg::FCB_DATA && st.write) begin
            case (st.idx)
                `FCB_IDX_CENTER: next_st.center = hwdata_i[`FCB_CENTER_REG_W-1:0];
                `FCB_IDX_TAP6:   next_st.tap6 = hwdata_i[`FCB_OUTER_REG_W-1:0];
                `FCB_IDX_TAP7:   next_st.tap7 = hwdata_i[`FCB_OUTER_REG_W-1:0];
                `FCB_IDX_TAP8:   next_st.tap8 = hwdata_i[`FCB_OUTER_REG_W-1:0];
                `FCB_IDX_TAP9:   next_st.tap9 = hwdata_i[`FCB_OUTER_REG_W-1:0];
                `FCB_IDX_MODE:   next_st.dual_mode = hwdata_i[0];
                default: begin
                    next_st.dual_mode = st.dual_mode;
                end
            endcase
        end
        // Reads answer in the data phase; unmapped reads return zero
        if (addr_take) begin
            next_st.phase  = fcb_pkg::FCB_DATA;
            next_st.write  = hwrite_i;
            next_st.idx    = haddr_i[`FCB_IDX_MSB:`FCB_IDX_LSB];
            next_st.hrdata = hwrite_i ? `FCB_RESET_VALUE : rd_mux;
        end else begin
            next_st.phase  = fcb_pkg::FCB_IDLE;
            next_st.write  = 1'b0;
            next_st.hrdata = `FCB_RESET_VALUE;
        end
        // signed fields only, reserved bits dropped
        next_st.coefs.center = next_st.center[`FCB_CENTER_COEF_W-1:0];
        next_st.coefs.tap6   = next_st.tap6[`FCB_OUTER_COEF_W-1:0];
        next_st.coefs.tap7   = next_st.tap7[`FCB_OUTER_COEF_W-1:0];
        next_st.coefs.tap8   = next_st.tap8[`FCB_OUTER_COEF_W-1:0];
        next_st.coefs.tap9   = next_st.tap9[`FCB_OUTER_COEF_W-1:0];
        next_st.coefs_valid  = next_st.dual_mode;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops, except hreadyout_o and hresp_o, which are tied to constants
    assign hrdata_o      = st.hrdata;
    assign hreadyout_o   = 1'b1;
    assign hresp_o       = 1'b0;
    assign coefs_o       = st.coefs;
    assign coefs_valid_o = st.coefs_valid;
    assign dual_mode_o   = st.dual_mode;

endmodule

`default_nettype wire

// ==== testbench/fcb_coef_bank_chk.sv ====
// Checker for the channel B upper-tap coefficient bank ports.
// Assumes binding to fcb_coef_bank; hready_i follows hreadyout_o.
`timescale 1ns/100ps
`default_nettype none
module fcb_chk (
    input wire logic                clk_i,
    input wire logic                sys_rst_i,
    input wire logic                hsel_i,
    input wire logic [31:0]         haddr_i,
    input wire logic [1:0]          htrans_i,
    input wire logic                hwrite_i,
    input wire logic [31:0]         hwdata_i,
    input wire logic                hready_i,
    input wire logic [31:0]         hrdata_o,
    input wire logic                hreadyout_o,
    input wire logic                hresp_o,
    input wire fcb_pkg::fcb_coefs_t coefs_o,
    input wire logic                coefs_valid_o,
    input wire logic                dual_mode_o
);
    // Transfer taken at this edge, and its register index
    wire logic        go = hsel_i && hready_i && htrans_i[1];
    wire logic [11:0] ix = haddr_i[13:2];
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_rst; $past(sys_rst_i) |-> coefs_o == '0 && !dual_mode_o && hrdata_o == '0; endproperty
    a_rst: assert property (p_rst) else $error("not zero after reset");
    property p_val; coefs_valid_o == dual_mode_o; endproperty
    a_val: assert property (p_val) else $error("valid differs from mode");
    // Writes land at the edge ending the data phase, seen one edge later
    property p_cen; go && hwrite_i && ix == 12'h450 |-> ##2 coefs_o.center == $past(hwdata_i[17:0]); endproperty
    a_cen: assert property (p_cen) else $error("center tap not stored");
    property p_t6; go && hwrite_i && ix == 12'h453 |-> ##2 coefs_o.tap6 == $past(hwdata_i[11:0]); endproperty
    a_t6: assert property (p_t6) else $error("tap6 not stored");
    property p_t7; go && hwrite_i && ix == 12'h455 |-> ##2 coefs_o.tap7 == $past(hwdata_i[11:0]); endproperty
    a_t7: assert property (p_t7) else $error("tap7 not stored");
    property p_t8; go && hwrite_i && ix == 12'h457 |-> ##2 coefs_o.tap8 == $past(hwdata_i[11:0]); endproperty
    a_t8: assert property (p_t8) else $error("tap8 not stored");
    property p_t9; go && hwrite_i && ix == 12'h459 |-> ##2 coefs_o.tap9 == $past(hwdata_i[11:0]); endproperty
    a_t9: assert property (p_t9) else $error("tap9 not stored");
    property p_rmo; go && !hwrite_i && ix == 12'h453 |=> hrdata_o[31:16] == '0 && !hrdata_o[11]; endproperty
    a_rmo: assert property (p_rmo) else $error("outer tap msb read back");
    property p_rmc; go && !hwrite_i && ix == 12'h450 |=> hrdata_o[31:24] == '0 && !hrdata_o[17]; endproperty
    a_rmc: assert property (p_rmc) else $error("center tap msb read back");
    property p_ok; hreadyout_o && !hresp_o; endproperty
    a_ok: assert property (p_ok) else $error("wait state or error response");
endmodule
bind fcb_coef_bank fcb_chk fcb_chk_i (.*);
`default_nettype wire

// ==== testbench/tb_fcb_coef_bank.sv ====
// Self-checking bench for the channel B upper-tap coefficient bank.
// Assumes the checker file is compiled alongside; one AHB-Lite master here.
`timescale 1ns/100ps
`default_nettype none
module tb_fcb_coef_bank;
    logic                clk_i     = 1'b0;
    logic                sys_rst_i = 1'b1;
    logic                hsel_i    = 1'b0;
    logic                hwrite_i  = 1'b0;
    logic [1:0]          htrans_i  = 2'h0;
    logic [31:0]         haddr_i   = 32'h0;
    logic [31:0]         hwdata_i  = 32'h0;
    logic [31:0]         hrdata_o, rd;
    logic                hreadyout_o, hresp_o, coefs_valid_o, dual_mode_o;
    fcb_pkg::fcb_coefs_t coefs_o;
    int                  num_errors = 0;
    int                  num_checks = 0;
    // Byte address, write data, readback with field msb cleared
    logic [31:0] rows [6][3] = '{
        '{32'h1140, 32'hffff_ffff, 32'h00fd_ffff},
        '{32'h114c, 32'h0000_f800, 32'h0000_f000},
        '{32'h1154, 32'h0000_0abc, 32'h0000_02bc},
        '{32'h115c, 32'h0000_07ff, 32'h0000_07ff},
        '{32'h1164, 32'h0000_1234, 32'h0000_1234},
        '{32'h1148, 32'h0000_5555, 32'h0000_0000}};
    fcb_coef_bank fcb_coef_bank_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .coefs_o(coefs_o),
        .coefs_valid_o(coefs_valid_o), .dual_mode_o(dual_mode_o));
    // 125 MHz clock
    always #4 clk_i = ~clk_i;
    task automatic chk(input logic [65:0] got, input logic [65:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Single word transfer; read data taken at the edge ending the data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= a;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog of 2500 cycles, well beyond the roughly 50 cycles the tests need
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        foreach (rows[i]) begin
            xfer(1'b0, rows[i][0], 32'h0);
            chk(rd, 32'h0);
        end
        xfer(1'b1, 32'h1180, 32'h1);
        @(posedge clk_i);
        chk({coefs_valid_o, dual_mode_o}, 2'h3);
        // Table: extreme signed values, reserved bits set, one unmapped slot
        foreach (rows[i]) xfer(1'b1, rows[i][0], rows[i][1]);
        @(posedge clk_i);
        chk(coefs_o, {18'h3ffff, 12'h800, 12'habc, 12'h7ff, 12'h234});
        foreach (rows[i]) begin
            xfer(1'b0, rows[i][0], 32'h0);
            chk(rd, rows[i][2]);
        end
        // Leaving dual-channel mode drops the coefficients' validity
        xfer(1'b1, 32'h1180, 32'h0);
        @(posedge clk_i);
        chk(coefs_valid_o, 1'b0);
        // Reset in mid-run clears every stored coefficient
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk(coefs_o, 66'h0);
        xfer(1'b0, 32'h1140, 32'h0);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
